// File: logic/mio_pkg.sv
// Constants for the multiplexed I/O port bank: register map, field layout and reset values.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and byte enables.
package mio_pkg;

  // ---------------------------------------------------------------------------
  // Bank geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned MIO_GEN_PORTS = 8;
  localparam int unsigned MIO_RT_PORTS  = 4;
  localparam int unsigned MIO_GEN_BITS  = 64;
  localparam int unsigned MIO_RT_BITS   = 32;
  localparam int unsigned MIO_EXT_BITS  = 10;
  localparam int unsigned MIO_ADDR_W    = 14;

  // ---------------------------------------------------------------------------
  // Register offsets within the bank window
  // ---------------------------------------------------------------------------
  localparam logic [13:0] MIO_GEN_BASE  = 14'h0000;
  localparam logic [13:0] MIO_RT_BASE   = 14'h0400;
  localparam logic [13:0] MIO_EXT_BASE  = 14'h0800;
  localparam logic [7:0]  MIO_OFS_PORT  = 8'h00;
  localparam logic [7:0]  MIO_OFS_DIR   = 8'h10;
  localparam logic [7:0]  MIO_OFS_FSEL  = 8'h20;
  localparam logic [7:0]  MIO_OFS_ALTL  = 8'h30;
  localparam logic [7:0]  MIO_OFS_ALTH  = 8'h40;
  localparam logic [7:0]  MIO_OFS_PIN   = 8'h50;
  localparam logic [7:0]  MIO_OFS_RTCTL = 8'h60;
  localparam logic [7:0]  MIO_HI_WORD   = 8'h04;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] MIO_RST_LATCH = 32'h0000_0000;
  localparam logic [31:0] MIO_RST_DIR   = 32'hFFFF_FFFF;
  localparam logic [31:0] MIO_RST_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Real-time control register fields
  // ---------------------------------------------------------------------------
  localparam int unsigned MIO_RTCTL_OUT_SYNC = 0;
  localparam int unsigned MIO_RTCTL_IN_SYNC  = 1;

  typedef enum logic [1:0]
  {
    MIO_IDLE = 2'b00,
    MIO_ACK  = 2'b01
  } mio_bus_e;

endpackage

// File: logic/mio_port_bank.sv
// Multiplexed I/O port bank: eight general ports, four real-time ports, one 10-bit extension port.
// Assumes an Avalon-MM master on sys_clk and peripheral modules that drive their own out/enable.
//
// How it works
// - Twelve eight-bit ports plus one ten-bit extension port.
// - Nine three-state general ports including extension, four real-time ports.
// - Direction chosen per pin bit in every port.
// - Ports grouped four bytes per word for single 32-bit access.
// - Byte, halfword and word accesses each address matching port group.
// - Register sets replicated for general 0-7, real-time 0-3, extension 0-1.
// - Real-time pins sample and update in step with interrupt strobes.
// - Output register write loads latch; read returns latch, not pin.
// - Direction register places each pin in input or output mode.
// - Function-versus-port select picks port or peripheral, readable.
// - Low and high alternate selects are stored and readable; no output uses them.
// - Pad level registers read pin level; writes ignored.
// - Input-function pins in peripheral mode, except on the extension port, also feed external interrupts.
// - Byte, halfword and word views share the group base address.
// - Output latches reset to zero.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.

`timescale 1ns/1ps

module mio_port_bank
  import mio_pkg::*;
(
  input  wire logic                    sys_clk,            // System clock, 100 MHz.
  input  wire logic                    rst,                // Asynchronous reset, active high.
  input  wire logic [MIO_ADDR_W-1:0]   avs_address,        // Byte address within the bank.
  input  wire logic                    avs_read,           // Read request.
  input  wire logic                    avs_write,          // Write request.
  input  wire logic [31:0]             avs_writedata,      // Write data.
  input  wire logic [3:0]              avs_byteenable,     // Byte lanes.
  output logic      [31:0]             avs_readdata,       // Read data.
  output logic                         avs_waitrequest,    // Stall while the answer is prepared.
  input  wire logic [MIO_GEN_BITS-1:0] gen_pad_in,         // General pad levels.
  output logic      [MIO_GEN_BITS-1:0] gen_pad_out,        // General pad drive value.
  output logic      [MIO_GEN_BITS-1:0] gen_pad_oe,         // General pad drive enable.
  input  wire logic [MIO_RT_BITS-1:0]  rt_pad_in,          // Real-time pad levels.
  output logic      [MIO_RT_BITS-1:0]  rt_pad_out,         // Real-time pad drive value.
  output logic      [MIO_RT_BITS-1:0]  rt_pad_oe,          // Real-time pad drive enable.
  input  wire logic [MIO_EXT_BITS-1:0] ext_pad_in,         // Extension pad levels.
  output logic      [MIO_EXT_BITS-1:0] ext_pad_out,        // Extension pad drive value.
  output logic      [MIO_EXT_BITS-1:0] ext_pad_oe,         // Extension pad drive enable.
  input  wire logic [MIO_GEN_BITS-1:0] gen_periph_out,     // Peripheral values, general pins.
  input  wire logic [MIO_GEN_BITS-1:0] gen_periph_oe,      // Peripheral enables, general pins.
  input  wire logic [MIO_RT_BITS-1:0]  rt_periph_out,      // Peripheral values, real-time pins.
  input  wire logic [MIO_RT_BITS-1:0]  rt_periph_oe,       // Peripheral enables, real-time pins.
  input  wire logic [MIO_EXT_BITS-1:0] ext_periph_out,     // Peripheral values, extension pins.
  input  wire logic [MIO_EXT_BITS-1:0] ext_periph_oe,      // Peripheral enables, extension pins.
  output logic      [MIO_GEN_BITS-1:0] gen_periph_in,      // Synchronised general pin levels.
  output logic      [MIO_RT_BITS-1:0]  rt_periph_in,       // Synchronised real-time pin levels.
  output logic      [MIO_EXT_BITS-1:0] ext_periph_in,      // Synchronised extension pin levels.
  output logic      [MIO_GEN_BITS-1:0] gen_extint_in,      // External interrupt feed, general pins.
  output logic      [MIO_RT_BITS-1:0]  rt_extint_in,       // External interrupt feed, real-time pins.
  input  wire logic [MIO_GEN_BITS-1:0] gen_extint_avail,   // Tie high where a pin offers an interrupt.
  input  wire logic [MIO_RT_BITS-1:0]  rt_extint_avail,    // Tie high where a pin offers an interrupt.
  input  wire logic                    rt_out_strobe,      // Interrupt strobe that updates RT outputs.
  input  wire logic                    rt_in_strobe        // Interrupt strobe that samples RT inputs.
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  // Five writable sets per group, index 0..4 = latch, direction, function select, alt low, alt high.
  logic [MIO_GEN_BITS-1:0] gen_q [5];
  logic [MIO_RT_BITS-1:0]  rt_q  [5];
  logic [MIO_EXT_BITS-1:0] ext_q [5];
  logic [1:0]              rt_ctl_q;
  logic [MIO_RT_BITS-1:0]  rt_out_shadow_q;
  logic [MIO_RT_BITS-1:0]  rt_in_hold_q;
  logic [MIO_GEN_BITS-1:0] gen_s1_q, gen_s2_q;
  logic [MIO_RT_BITS-1:0]  rt_s1_q, rt_s2_q;
  logic [MIO_EXT_BITS-1:0] ext_s1_q, ext_s2_q;
  logic [1:0]              rts_s1_q, rts_s2_q, rts_s3_q;
  mio_bus_e                bus_q;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Returns the register set 0..5 or 6 for the control word, 7 for unmapped.
  function automatic logic [2:0] set_of(input logic [7:0] ofs);
    if (ofs[7:4] <= MIO_OFS_PIN[7:4])
      set_of = ofs[6:4];
    else if (ofs[7:3] == MIO_OFS_RTCTL[7:3])
      set_of = 3'd6;
    else
      set_of = 3'd7;
  endfunction

  // Byte-lane merge: only enabled lanes take new data.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
  endfunction

  logic [1:0]  grp;
  logic [2:0]  set;
  logic        hi_word;
  logic        wr_en;
  assign grp     = avs_address[11:10];
  assign set     = set_of(avs_address[7:0]);
  assign hi_word = avs_address[2];
  assign wr_en   = avs_write && (bus_q == MIO_IDLE);

  // The merge result is held in a full word so that its lower bits can be selected.
  logic [31:0] ext_wr_v;
  assign ext_wr_v = merge({22'h0, ext_q[set]}, avs_writedata, avs_byteenable);

  // ---------------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------------
  // One wait cycle gives registered read data without a long address-to-data path.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      bus_q <= MIO_IDLE;
    else if (bus_q == MIO_ACK)
      bus_q <= MIO_IDLE;
    else if (avs_read || avs_write)
      bus_q <= MIO_ACK;
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_q == MIO_IDLE);

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Byte lanes within the word pick the ports: lane k of the word at base+4*h is port 4*h+k.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int s = 0; s < 5; s++)
      begin
        gen_q[s] <= (s == 1) ? {MIO_RST_DIR, MIO_RST_DIR} : {MIO_RST_LATCH, MIO_RST_LATCH};
        rt_q[s]  <= (s == 1) ? MIO_RST_DIR : MIO_RST_LATCH;
        ext_q[s] <= (s == 1) ? MIO_RST_DIR[MIO_EXT_BITS-1:0] : MIO_RST_LATCH[MIO_EXT_BITS-1:0];
      end
      rt_ctl_q <= MIO_RST_ZERO[1:0];
    end
    else if (wr_en && set < 3'd5)
    begin
      if (grp == MIO_GEN_BASE[11:10])
      begin
        if (hi_word)
          gen_q[set][63:32] <= merge(gen_q[set][63:32], avs_writedata, avs_byteenable);
        else
          gen_q[set][31:0] <= merge(gen_q[set][31:0], avs_writedata, avs_byteenable);
      end
      else if (grp == MIO_RT_BASE[11:10] && !hi_word)
        rt_q[set] <= merge(rt_q[set], avs_writedata, avs_byteenable);
      else if (grp == MIO_EXT_BASE[11:10] && !hi_word)
        ext_q[set] <= ext_wr_v[MIO_EXT_BITS-1:0];
    end
    else if (wr_en && set == 3'd6 && grp == MIO_RT_BASE[11:10] && avs_byteenable[0])
      rt_ctl_q <= avs_writedata[1:0];
  end

  // ---------------------------------------------------------------------------
  // Pad synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      gen_s1_q <= '0;
      gen_s2_q <= '0;
      rt_s1_q  <= '0;
      rt_s2_q  <= '0;
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      rts_s1_q <= '0;
      rts_s2_q <= '0;
      rts_s3_q <= '0;
    end
    else
    begin
      gen_s1_q <= gen_pad_in;
      gen_s2_q <= gen_s1_q;
      rt_s1_q  <= rt_pad_in;
      rt_s2_q  <= rt_s1_q;
      ext_s1_q <= ext_pad_in;
      ext_s2_q <= ext_s1_q;
      rts_s1_q <= {rt_in_strobe, rt_out_strobe};
      rts_s2_q <= rts_s1_q;
      rts_s3_q <= rts_s2_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Real-time synchronous transfer
  // ---------------------------------------------------------------------------
  // Rising edges of the interrupt strobes move the latch to the pins and the pins to the hold.
  logic out_evt, in_evt;
  assign out_evt = rts_s2_q[0] && !rts_s3_q[0];
  assign in_evt  = rts_s2_q[1] && !rts_s3_q[1];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rt_out_shadow_q <= MIO_RST_LATCH;
      rt_in_hold_q    <= MIO_RST_ZERO;
    end
    else
    begin
      if (!rt_ctl_q[MIO_RTCTL_OUT_SYNC] || out_evt)
        rt_out_shadow_q <= rt_q[0];
      if (!rt_ctl_q[MIO_RTCTL_IN_SYNC] || in_evt)
        rt_in_hold_q <= rt_s2_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Pad drive
  // ---------------------------------------------------------------------------
  // Direction bit 1 means input; the peripheral owns the pin in function mode.
  always_comb
  begin
    for (int b = 0; b < MIO_GEN_BITS; b++)
    begin
      gen_pad_out[b] = gen_q[2][b] ? gen_periph_out[b] : gen_q[0][b];
      gen_pad_oe[b]  = gen_q[2][b] ? gen_periph_oe[b]  : !gen_q[1][b];
    end
    for (int b = 0; b < MIO_RT_BITS; b++)
    begin
      rt_pad_out[b] = rt_q[2][b] ? rt_periph_out[b] : rt_out_shadow_q[b];
      rt_pad_oe[b]  = rt_q[2][b] ? rt_periph_oe[b]  : !rt_q[1][b];
    end
    for (int b = 0; b < MIO_EXT_BITS; b++)
    begin
      ext_pad_out[b] = ext_q[2][b] ? ext_periph_out[b] : ext_q[0][b];
      ext_pad_oe[b]  = ext_q[2][b] ? ext_periph_oe[b]  : !ext_q[1][b];
    end
  end

  // ---------------------------------------------------------------------------
  // Peripheral and interrupt feeds
  // ---------------------------------------------------------------------------
  // Function selections outside a pin's allocation are passed through unchecked.
  assign gen_periph_in = gen_s2_q;
  assign rt_periph_in  = rt_s2_q;
  assign ext_periph_in = ext_s2_q;
  assign gen_extint_in = gen_s2_q & gen_q[2] & ~gen_periph_oe & gen_extint_avail;
  assign rt_extint_in  = rt_s2_q & rt_q[2] & ~rt_periph_oe & rt_extint_avail;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  // All lanes are returned; the master picks the ones it asked for.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= MIO_RST_ZERO;
    else if (avs_read && bus_q == MIO_IDLE)
    begin
      avs_readdata <= MIO_RST_ZERO;
      if (set == 3'd6 && grp == MIO_RT_BASE[11:10])
        avs_readdata <= {30'h0, rt_ctl_q};
      else if (set < 3'd6 && grp == MIO_GEN_BASE[11:10])
      begin
        if (set == 3'd5)
          avs_readdata <= hi_word ? gen_s2_q[63:32] : gen_s2_q[31:0];
        else
          avs_readdata <= hi_word ? gen_q[set][63:32] : gen_q[set][31:0];
      end
      else if (set < 3'd6 && grp == MIO_RT_BASE[11:10] && !hi_word)
        avs_readdata <= (set == 3'd5) ? rt_in_hold_q : rt_q[set];
      else if (set < 3'd6 && grp == MIO_EXT_BASE[11:10] && !hi_word)
        avs_readdata <= {22'h0, (set == 3'd5) ? ext_s2_q : ext_q[set]};
    end
  end

endmodule

// File: testbench/mio_pad_model.sv
// Pad model: resolves every pad from the bank's drive and an outside driver.
// Assumes a weak outside driver, so the bank wins wherever its enable is high.
`timescale 1ns/1ps
module mio_pad_model
#(
  parameter int N = 8
)
(
  input  wire logic [N-1:0] pad_out,   // Bank drive value.
  input  wire logic [N-1:0] pad_oe,    // Bank drive enable.
  input  wire logic [N-1:0] ext_drive, // Level set by the outside world.
  output logic      [N-1:0] pad_in     // Resolved pad level.
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive);
endmodule

// File: testbench/mio_port_bank_sva.sv
// Checker for the port bank: bus handshake, reset drive state and input paths.
// Assumes it is bound to mio_port_bank and sees only its ports.
`timescale 1ns/1ps
module mio_port_bank_sva
  import mio_pkg::*;
(
  input wire logic                    sys_clk,          // Clock.
  input wire logic                    rst,              // Reset.
  input wire logic [MIO_ADDR_W-1:0]   avs_address,      // Address.
  input wire logic                    avs_read,         // Read.
  input wire logic                    avs_write,        // Write.
  input wire logic [31:0]             avs_readdata,     // Read data.
  input wire logic                    avs_waitrequest,  // Stall.
  input wire logic [MIO_GEN_BITS-1:0] gen_pad_in,       // Pad levels.
  input wire logic [MIO_GEN_BITS-1:0] gen_pad_oe,       // Pad enables.
  input wire logic [MIO_RT_BITS-1:0]  rt_pad_oe,        // Pad enables.
  input wire logic [MIO_EXT_BITS-1:0] ext_pad_oe,       // Pad enables.
  input wire logic [MIO_GEN_BITS-1:0] gen_periph_oe,    // Peripheral enables.
  input wire logic [MIO_GEN_BITS-1:0] gen_periph_in,    // Synced levels.
  input wire logic [MIO_GEN_BITS-1:0] gen_extint_in,    // Interrupt feed.
  input wire logic [MIO_GEN_BITS-1:0] gen_extint_avail  // Interrupt pins.
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request stalled more than one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("stall without request");
  a_reset_input: assert property ($fell(rst) |-> gen_pad_oe == '0 && rt_pad_oe == '0 && ext_pad_oe == '0)
    else $error("pad driven straight after reset");
  a_read_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_ext_upper: assert property (avs_read && !avs_waitrequest && avs_address[11:10] == 2'b10
    |-> avs_readdata[31:10] == 22'h0)
    else $error("extension read shows upper bits");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7:0] >= 8'h70
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_sync_delay: assert property (gen_periph_in == $past(gen_pad_in, 2))
    else $error("synced pad level not two cycles late");
  a_extint_gate: assert property ((gen_extint_in & ~(gen_periph_in & gen_extint_avail & ~gen_periph_oe)) == '0)
    else $error("interrupt feed outside its gate");
endmodule

bind mio_port_bank mio_port_bank_sva chk (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .gen_pad_in(gen_pad_in), .gen_pad_oe(gen_pad_oe), .rt_pad_oe(rt_pad_oe), .ext_pad_oe(ext_pad_oe),
  .gen_periph_oe(gen_periph_oe), .gen_periph_in(gen_periph_in), .gen_extint_in(gen_extint_in),
  .gen_extint_avail(gen_extint_avail));

// File: testbench/mio_port_bank_test.sv
// Self-checking bench for the port bank with a register and pad model.
// Assumes the one-wait Avalon-MM slave timing of the bank.
`timescale 1ns/1ps
module mio_port_bank_test
  import mio_pkg::*;
;
  logic        sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, so = 0, si = 0;
  logic [13:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, r_out, r_oe, r_in, r_pin, r_int, ravail, oldv;
  logic [3:0]  avs_byteenable = '0;
  logic [63:0] g_out, g_oe, g_in, g_pin, g_int, gavail;
  logic [9:0]  e_out, e_oe, e_in, e_pin;
  logic [31:0] po[4], poe[4], drv[4], m[int];
  int          base[4] = '{0, 4, 'h400, 'h800};
  int          ofs[7] = '{0, 'h10, 'h20, 'h30, 'h40, 'h50, 'h70}; // Latch first, then mode.
  int          bad_count = 0, checks = 0, cyc = 0;

  always #5 sys_clk = ~sys_clk;

  mio_port_bank DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gen_pad_in(g_pin), .gen_pad_out(g_out),
    .gen_pad_oe(g_oe), .rt_pad_in(r_pin), .rt_pad_out(r_out), .rt_pad_oe(r_oe), .ext_pad_in(e_pin),
    .ext_pad_out(e_out), .ext_pad_oe(e_oe), .gen_periph_out({po[1], po[0]}), .gen_periph_oe({poe[1], poe[0]}),
    .rt_periph_out(po[2]), .rt_periph_oe(poe[2]), .ext_periph_out(po[3][9:0]), .ext_periph_oe(poe[3][9:0]),
    .gen_periph_in(g_in), .rt_periph_in(r_in), .ext_periph_in(e_in), .gen_extint_in(g_int),
    .rt_extint_in(r_int), .gen_extint_avail(gavail), .rt_extint_avail(ravail), .rt_out_strobe(so),
    .rt_in_strobe(si));
  mio_pad_model #(.N(64)) pg (.pad_out(g_out), .pad_oe(g_oe), .ext_drive({drv[1], drv[0]}), .pad_in(g_pin));
  mio_pad_model #(.N(32)) pr (.pad_out(r_out), .pad_oe(r_oe), .ext_drive(drv[2]), .pad_in(r_pin));
  mio_pad_model #(.N(10)) pe (.pad_out(e_out), .pad_oe(e_oe), .ext_drive(drv[3][9:0]), .pad_in(e_pin));

  // ---------------------------------------------------------------------------
  // Model of the register file and pads
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] msk(int i);
    return (i == 3) ? 32'h0000_03FF : 32'hFFFF_FFFF;
  endfunction
  function automatic logic [31:0] rv(int a);
    return m.exists(a) ? m[a] : 32'h0000_0000;
  endfunction
  function automatic logic [31:0] pout(int i);
    return ((rv(base[i] + 'h20) & po[i]) | (~rv(base[i] + 'h20) & rv(base[i]))) & msk(i);
  endfunction
  function automatic logic [31:0] poen(int i);
    return ((rv(base[i] + 'h20) & poe[i]) | (~rv(base[i] + 'h20) & ~rv(base[i] + 'h10))) & msk(i);
  endfunction
  function automatic logic [31:0] pin(int i);
    return ((poen(i) & pout(i)) | (~poen(i) & drv[i])) & msk(i);
  endfunction
  function automatic logic [31:0] pick(logic [63:0] g, logic [31:0] r, logic [9:0] e, int i);
    return (i < 2) ? g[i*32+:32] : (i == 2) ? r : {22'h0, e};
  endfunction

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(bit w, int a, logic [31:0] d, logic [3:0] be, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a[13:0];
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(int i, int o, logic [31:0] d, logic [3:0] be);
    logic [31:0] q, bm;
    int a;
    a = base[i] + o;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1, a, d, be, q);
    if (o < 'h50 || a == 'h460) m[a] = ((rv(a) & ~bm) | (d & bm)) & msk(i);
  endtask
  task automatic rd(int i, int o, logic [31:0] e);
    logic [31:0] q;
    bus(0, base[i] + o, '0, 4'hF, q);
    chk(q, e);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    void'($urandom(12161));
    for (int i = 0; i < 4; i++) {po[i], poe[i], drv[i]} = '0;
    gavail = {$urandom, $urandom};
    ravail = $urandom;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) m[base[i] + 'h10] = msk(i); // All pins start as inputs.
    foreach (ofs[k]) for (int i = 0; i < 4; i++) rd(i, ofs[k], ofs[k] == 'h50 ? pin(i) : rv(base[i] + ofs[k]));
    repeat (4)
    begin
      // Peripheral drive changes between rounds; alt selects are only stored.
      for (int i = 0; i < 4; i++) {po[i], poe[i], drv[i]} <= {$urandom, $urandom, $urandom};
      foreach (ofs[k]) for (int i = 0; i < 4; i++) wr(i, ofs[k], $urandom, 4'($urandom));
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 4; i++)
      begin
        chk(pick(g_out, r_out, e_out, i), pout(i));
        chk(pick(g_oe, r_oe, e_oe, i), poen(i));
        chk(pick(g_in, r_in, e_in, i), pin(i));
        chk(pick(g_int, r_int, 10'h0, i), pin(i) & rv(base[i] + 'h20) & ~poe[i] & pick(gavail, ravail, 10'h0, i));
      end
      foreach (ofs[k]) for (int i = 0; i < 4; i++) rd(i, ofs[k], ofs[k] == 'h50 ? pin(i) : rv(base[i] + ofs[k]));
    end
    wr(2, 'h10, 32'h0, 4'hF);
    wr(2, 'h20, 32'h0, 4'hF);
    wr(2, 'h60, 32'h1, 4'hF);
    oldv = rv('h400);
    wr(2, 0, ~oldv, 4'hF);
    repeat (6) @(posedge sys_clk);
    chk(r_out, oldv);
    so <= 1'b1;
    repeat (2) @(posedge sys_clk);
    so <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(r_out, ~oldv);
    wr(2, 'h10, 32'hFFFF_FFFF, 4'hF);
    wr(2, 'h60, 32'h3, 4'hF);
    oldv = drv[2];
    si <= 1'b1;
    repeat (2) @(posedge sys_clk);
    si <= 1'b0;
    repeat (6) @(posedge sys_clk);
    drv[2] <= ~oldv;
    repeat (6) @(posedge sys_clk);
    rd(2, 'h50, oldv);
    results();
  end
endmodule
